//--- design/pfc_checker.sv
// Frame checker core: frame and error counters with read snapshot.
`timescale 1ns/1ps
module pfc_checker (
	input wire logic aclk,
	input wire logic aresetn,
	pfc_chk_if.chk ctl,
	input wire logic tx_frame_done,
	input wire logic tx_crc_err,
	input wire logic tx_frame_err,
	input wire logic rx_frame_done,
	input wire logic rx_crc_err,
	input wire logic rx_frame_err
);
	typedef struct packed {
		logic [31:0] frame_cnt;
		logic [15:0] err_cnt;
		logic [31:0] snap;
		logic err_evt;
	} pfc_chk_state_t;

	pfc_chk_state_t s_reg;
	pfc_chk_state_t s_next;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic done;
		logic bad;
		logic hit;
		done = 1'b0;
		bad = 1'b0;
		hit = 1'b0;
		s_next = s_reg;
		if (ctl.path_sel) begin
			done = tx_frame_done;
			bad = tx_crc_err | tx_frame_err;
		end else begin
			done = rx_frame_done;
			bad = rx_crc_err | rx_frame_err;
		end
		hit = ctl.enable & done;
		s_next.err_evt = hit & bad;
		if (hit) begin
			s_next.frame_cnt = s_reg.frame_cnt + 32'h1;
		end
		// An error landing in the clearing cycle is kept as the first new count.
		if (ctl.rd_clr) begin
			s_next.snap = s_reg.frame_cnt;
			s_next.err_cnt = (hit & bad) ? 16'h1 : 16'h0;
		end else if (hit & bad && s_reg.err_cnt != 16'hFFFF) begin
			s_next.err_cnt = s_reg.err_cnt + 16'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign ctl.err_evt = s_reg.err_evt;
	assign ctl.err_cnt = s_reg.err_cnt;
	assign ctl.snap = s_reg.snap;
endmodule : pfc_checker

//--- design/pfc_chk_if.sv
// Interface between the register block and the frame checker core.
`timescale 1ns/1ps
interface pfc_chk_if;
	logic enable;
	logic path_sel;
	logic rd_clr;
	logic err_evt;
	logic [15:0] err_cnt;
	logic [31:0] snap;
	modport ctrl (output enable, output path_sel, output rd_clr,
		input err_evt, input err_cnt, input snap);
	modport chk (input enable, input path_sel, input rd_clr,
		output err_evt, output err_cnt, output snap);
endinterface : pfc_chk_if

//--- design/pfc_pkg.sv
// Package for the frame checker and interrupt mask block.
package pfc_pkg;
	localparam int ADDR_W = 18;
	localparam logic [15:0] IDX_STATUS = 16'h0011;
	localparam logic [15:0] IDX_MASK = 16'h0021;
	localparam logic [15:0] IDX_CHECKER_ENABLE = 16'h8001;
	localparam logic [15:0] IDX_IRQ_EN = 16'h8004;
	localparam logic [15:0] IDX_PATH = 16'h8005;
	localparam logic [15:0] IDX_RX_ERR = 16'h8008;
	localparam logic [15:0] IDX_SNAP_H = 16'h8009;
	localparam logic [15:0] IDX_SNAP_L = 16'h800A;
	localparam int BIT_SELF_CLR = 15;
	localparam int BIT_CHECKER = 14;
	localparam int BIT_BUFFER = 13;
	localparam int BIT_NEGOTIATION = 11;
	localparam int BIT_LINK = 1;
	localparam int BIT_ENABLE = 0;
	localparam logic [15:0] MASK_RST = 16'h2402;
	localparam logic [15:0] EVENT_BITS = 16'h6802;
	localparam logic CHECKER_ENABLE_RST = 1'h1;
	localparam logic IRQ_EN_RST = 1'h1;
	localparam logic PATH_RST = 1'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : pfc_pkg

//--- design/pfc_top.sv
// Top of the frame checker block: AXI4-Lite registers, flags and interrupt.
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
module pfc_top #(
	parameter int ADDR_W = pfc_pkg::ADDR_W
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic tx_frame_done,
	input wire logic tx_crc_err,
	input wire logic tx_frame_err,
	input wire logic rx_frame_done,
	input wire logic rx_crc_err,
	input wire logic rx_frame_err,
	input wire logic buffer_error_evt,
	input wire logic negotiation_change_evt,
	input wire logic link_change_evt,
	output logic irq
);
	////////////////////////////////////////////////////////////////////////
	// The highest register index times four must fit the address.
	if (ADDR_W < 18 || ADDR_W > 32) begin : g_addr_check
		$error("pfc_top: ADDR_W must lie between 18 and 32");
	end

	typedef struct packed {
		logic aw_rdy;
		logic [ADDR_W-1:0] aw_addr;
		logic w_rdy;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic b_valid;
		logic [1:0] b_resp;
		logic ar_rdy;
		logic r_valid;
		logic [31:0] r_data;
		logic [1:0] r_resp;
		logic [15:0] mask;
		logic checker_enable;
		logic irq_en;
		logic path_sel;
		logic [15:0] flags;
		logic irq;
	} pfc_top_state_t;

	pfc_top_state_t s_reg;
	pfc_top_state_t s_next;
	pfc_chk_if chk_bus ();
	logic rd_take;
	logic [15:0] rd_idx;

	////////////////////////////////////////////////////////////////////////
	pfc_checker u_checker (
		.aclk(aclk),
		.aresetn(aresetn),
		.ctl(chk_bus),
		.tx_frame_done(tx_frame_done),
		.tx_crc_err(tx_crc_err),
		.tx_frame_err(tx_frame_err),
		.rx_frame_done(rx_frame_done),
		.rx_crc_err(rx_crc_err),
		.rx_frame_err(rx_frame_err)
	);

	// Byte address is four times the register index; low bits are ignored.
	assign rd_idx = s_axi_araddr[17:2];
	assign rd_take = s_reg.ar_rdy & s_axi_arvalid;
	assign chk_bus.enable = s_reg.checker_enable;
	assign chk_bus.path_sel = s_reg.path_sel;
	// The clear is raised in the take cycle so the returned count and snapshot agree.
	assign chk_bus.rd_clr = rd_take && rd_idx == pfc_pkg::IDX_RX_ERR;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [15:0] wr_idx;
		logic [15:0] set_bits;
		logic [15:0] clr_bits;
		logic [15:0] wd;
		wr_idx = s_reg.aw_addr[17:2];
		set_bits = 16'h0;
		clr_bits = 16'h0;
		wd = s_reg.w_data[15:0];
		s_next = s_reg;

		// Hardware events latch without regard to the mask.
		set_bits[pfc_pkg::BIT_CHECKER] = chk_bus.err_evt & s_reg.irq_en;
		set_bits[pfc_pkg::BIT_BUFFER] = buffer_error_evt;
		set_bits[pfc_pkg::BIT_NEGOTIATION] = negotiation_change_evt;
		set_bits[pfc_pkg::BIT_LINK] = link_change_evt;

		// The reserved top mask bit holds for one cycle after a write, then clears itself.
		s_next.mask[pfc_pkg::BIT_SELF_CLR] = 1'b0;

		if (s_reg.aw_rdy && s_axi_awvalid) begin
			s_next.aw_rdy = 1'b0;
			s_next.aw_addr = s_axi_awaddr;
		end
		if (s_reg.w_rdy && s_axi_wvalid) begin
			s_next.w_rdy = 1'b0;
			s_next.w_data = s_axi_wdata;
			s_next.w_strb = s_axi_wstrb;
		end
		if (s_reg.b_valid && s_axi_bready) begin
			s_next.b_valid = 1'b0;
		end

		// A write is carried out once address and data are both held.
		if (!s_reg.aw_rdy && !s_reg.w_rdy && !s_reg.b_valid) begin
			s_next.aw_rdy = 1'b1;
			s_next.w_rdy = 1'b1;
			s_next.b_valid = 1'b1;
			s_next.b_resp = pfc_pkg::RESP_OKAY;
			case (wr_idx)
				pfc_pkg::IDX_MASK: begin
					if (s_reg.w_strb[0]) begin
						s_next.mask[7:0] = wd[7:0];
					end
					if (s_reg.w_strb[1]) begin
						s_next.mask[15:8] = wd[15:8];
					end
				end
				pfc_pkg::IDX_STATUS: begin
					if (s_reg.w_strb[0]) begin
						clr_bits[7:0] = wd[7:0];
					end
					if (s_reg.w_strb[1]) begin
						clr_bits[15:8] = wd[15:8];
					end
				end
				pfc_pkg::IDX_CHECKER_ENABLE: begin
					if (s_reg.w_strb[0]) begin
						s_next.checker_enable = wd[pfc_pkg::BIT_ENABLE];
					end
				end
				pfc_pkg::IDX_IRQ_EN: begin
					if (s_reg.w_strb[0]) begin
						s_next.irq_en = wd[pfc_pkg::BIT_ENABLE];
					end
				end
				pfc_pkg::IDX_PATH: begin
					if (s_reg.w_strb[0]) begin
						s_next.path_sel = wd[pfc_pkg::BIT_ENABLE];
					end
				end
				pfc_pkg::IDX_RX_ERR, pfc_pkg::IDX_SNAP_H, pfc_pkg::IDX_SNAP_L: begin
					s_next.b_resp = pfc_pkg::RESP_OKAY;
				end
				default: begin
					s_next.b_resp = pfc_pkg::RESP_DECERR;
				end
			endcase
		end

		if (s_reg.r_valid && s_axi_rready) begin
			s_next.r_valid = 1'b0;
			s_next.ar_rdy = 1'b1;
		end
		if (rd_take) begin
			s_next.ar_rdy = 1'b0;
			s_next.r_valid = 1'b1;
			s_next.r_resp = pfc_pkg::RESP_OKAY;
			s_next.r_data = 32'h0;
			case (rd_idx)
				pfc_pkg::IDX_MASK: begin
					s_next.r_data[15:0] = s_reg.mask;
				end
				pfc_pkg::IDX_STATUS: begin
					s_next.r_data[15:0] = s_reg.flags;
					clr_bits = clr_bits | s_reg.flags;
				end
				pfc_pkg::IDX_CHECKER_ENABLE: begin
					s_next.r_data[pfc_pkg::BIT_ENABLE] = s_reg.checker_enable;
				end
				pfc_pkg::IDX_IRQ_EN: begin
					s_next.r_data[pfc_pkg::BIT_ENABLE] = s_reg.irq_en;
				end
				pfc_pkg::IDX_PATH: begin
					s_next.r_data[pfc_pkg::BIT_ENABLE] = s_reg.path_sel;
				end
				pfc_pkg::IDX_RX_ERR: begin
					s_next.r_data[15:0] = chk_bus.err_cnt;
				end
				pfc_pkg::IDX_SNAP_H: begin
					s_next.r_data[15:0] = chk_bus.snap[31:16];
				end
				pfc_pkg::IDX_SNAP_L: begin
					s_next.r_data[15:0] = chk_bus.snap[15:0];
				end
				default: begin
					s_next.r_resp = pfc_pkg::RESP_DECERR;
				end
			endcase
		end

		// A new event wins over a clear in the same cycle.
		s_next.flags = ((s_reg.flags & ~clr_bits) | set_bits) & pfc_pkg::EVENT_BITS;
		s_next.irq = |(s_next.flags & s_next.mask);
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
			s_reg.aw_rdy <= 1'b1;
			s_reg.w_rdy <= 1'b1;
			s_reg.ar_rdy <= 1'b1;
			s_reg.mask <= pfc_pkg::MASK_RST;
			s_reg.checker_enable <= pfc_pkg::CHECKER_ENABLE_RST;
			s_reg.irq_en <= pfc_pkg::IRQ_EN_RST;
			s_reg.path_sel <= pfc_pkg::PATH_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign s_axi_awready = s_reg.aw_rdy;
	assign s_axi_wready = s_reg.w_rdy;
	assign s_axi_bvalid = s_reg.b_valid;
	assign s_axi_bresp = s_reg.b_resp;
	assign s_axi_arready = s_reg.ar_rdy;
	assign s_axi_rvalid = s_reg.r_valid;
	assign s_axi_rdata = s_reg.r_data;
	assign s_axi_rresp = s_reg.r_resp;
	assign irq = s_reg.irq;
endmodule : pfc_top

//--- verif/pfc_properties.sv
// Checker of bus answers and interrupt timing at the top ports.
`timescale 1ns/1ps
module pfc_properties (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic tx_frame_done,
	input wire logic rx_frame_done,
	input wire logic buffer_error_evt,
	input wire logic negotiation_change_evt,
	input wire logic link_change_evt,
	input wire logic irq
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// A frame reaches irq two edges late, so causes are looked for up to three edges back.
	// A mask write lifts irq on the edge that raises bvalid, so a standing bvalid counts too.
	logic cause;
	assign cause = buffer_error_evt | negotiation_change_evt | link_change_evt | tx_frame_done
		| rx_frame_done | s_axi_bvalid;
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("read answer dropped early");
	a_write_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write answer dropped early");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write not answered");
	a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read half not zero");
	a_decerr_data: assert property (s_axi_rvalid && s_axi_rresp == 2'h3 |-> s_axi_rdata == 0)
		else $error("refused read carries data");
	a_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("second read takeable");
	a_irq_cause: assert property ($rose(irq) |-> s_axi_bvalid || $past(cause)
		|| $past(cause, 2) || $past(cause, 3)) else $error("irq rose without cause");
	a_irq_hold: assert property ($fell(irq) |-> s_axi_rvalid || s_axi_bvalid
		|| $past(s_axi_bvalid)) else $error("irq fell without access");
	c_irq: cover property ($rose(irq));
	c_decerr: cover property (s_axi_bvalid && s_axi_bresp == 2'h3);
	c_data: cover property (s_axi_rvalid && s_axi_rdata != 0);
	c_wait: cover property (s_axi_rvalid && !s_axi_rready);
endmodule : pfc_properties
bind pfc_top pfc_properties u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_frame_done,
	.rx_frame_done, .buffer_error_evt, .negotiation_change_evt, .link_change_evt, .irq);

//--- verif/testbench.sv
// Register-level testbench of the frame checker block.
`timescale 1ns/1ps
module testbench;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [pfc_pkg::ADDR_W-1:0] s_axi_awaddr = '0;
	logic [pfc_pkg::ADDR_W-1:0] s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	// Frame inputs: tx done, crc, error, then rx done, crc, error; events buffer, nego, link.
	logic [5:0] fi = 6'h00;
	logic [2:0] ev = 3'h0;
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;
	// A slow master raises its ready only once the answer is seen, so answers must stand.
	logic slow = 1'b0;
	logic [15:0] ri [8] = '{16'h0011, 16'h0021, 16'h8001, 16'h8004, 16'h8005, 16'h8008,
		16'h8009, 16'h800A};
	logic [15:0] re [8] = '{16'h0000, 16'h2402, 16'h0001, 16'h0001, 16'h0000, 16'h0000,
		16'h0000, 16'h0000};
	int eb [3] = '{1, 11, 13};
	pfc_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .tx_frame_done(fi[5]), .tx_crc_err(fi[4]),
		.tx_frame_err(fi[3]), .rx_frame_done(fi[2]), .rx_crc_err(fi[1]), .rx_frame_err(fi[0]),
		.buffer_error_evt(ev[2]), .negotiation_change_evt(ev[1]), .link_change_evt(ev[0]),
		.irq);
	always #25 aclk = ~aclk;
	//////////////////////////////////////////////////////////////////////////////////////////
	task summarize;
		if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : summarize
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Ready and answers are sampled at the falling edge, where nothing the bench drives moves.
	task wr(input logic [15:0] idx, input logic [15:0] d, input logic [1:0] er);
		logic ta, tw, tb, tv;
		@(posedge aclk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= !slow;
		tb = 1'b0;
		while (!tb) begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid && s_axi_bready;
			tv = s_axi_bvalid;
			if (tb) chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) s_axi_bready <= 1'b0;
			else if (tv) s_axi_bready <= 1'b1;
		end
	endtask : wr
	task rdc(input logic [15:0] idx, input logic [15:0] e, input logic [1:0] er);
		logic ta, tr, tv;
		@(posedge aclk);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= !slow;
		tr = 1'b0;
		while (!tr) begin
			@(negedge aclk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid && s_axi_rready;
			tv = s_axi_rvalid;
			if (tr) chk("rdata", {16'h0000, e}, s_axi_rdata);
			if (tr) chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tr) s_axi_rready <= 1'b0;
			else if (tv) s_axi_rready <= 1'b1;
		end
	endtask : rdc
	task pulse(input logic [8:0] v);
		@(posedge aclk);
		{fi, ev} <= v;
		@(posedge aclk);
		{fi, ev} <= 9'h000;
		repeat (3) @(posedge aclk);
	endtask : pulse
	task irqc(input logic e);
		@(negedge aclk);
		chk("irq", {31'h0, e}, {31'h0, irq});
	endtask : irqc
	//////////////////////////////////////////////////////////////////////////////////////////
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			summarize();
		end
	end
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		irqc(1'b0);
		for (int i = 0; i < 8; i++) begin
			rdc(ri[i], re[i], 2'h0);
		end
		wr(pfc_pkg::IDX_MASK, 16'hFFFF, 2'h0);
		rdc(pfc_pkg::IDX_MASK, 16'h7FFF, 2'h0);
		s_axi_wstrb <= 4'h1;
		wr(pfc_pkg::IDX_MASK, 16'h0000, 2'h0);
		rdc(pfc_pkg::IDX_MASK, 16'h7F00, 2'h0);
		s_axi_wstrb <= 4'hF;
		wr(pfc_pkg::IDX_MASK, 16'h0000, 2'h0);
		pulse(9'h007);
		irqc(1'b0);
		rdc(pfc_pkg::IDX_STATUS, 16'h2802, 2'h0);
		rdc(pfc_pkg::IDX_STATUS, 16'h0000, 2'h0);
		pulse(9'h007);
		wr(pfc_pkg::IDX_STATUS, 16'h0802, 2'h0);
		rdc(pfc_pkg::IDX_STATUS, 16'h2000, 2'h0);
		for (int i = 0; i < 3; i++) begin
			wr(pfc_pkg::IDX_MASK, 16'h0001 << eb[i], 2'h0);
			pulse(9'h007);
			irqc(1'b1);
			rdc(pfc_pkg::IDX_STATUS, 16'h2802, 2'h0);
			irqc(1'b0);
		end
		wr(pfc_pkg::IDX_MASK, 16'h4000, 2'h0);
		pulse(9'h020);
		pulse(9'h030);
		pulse(9'h028);
		pulse(9'h180);
		irqc(1'b1);
		rdc(pfc_pkg::IDX_STATUS, 16'h4000, 2'h0);
		rdc(pfc_pkg::IDX_RX_ERR, 16'h0002, 2'h0);
		rdc(pfc_pkg::IDX_SNAP_H, 16'h0000, 2'h0);
		rdc(pfc_pkg::IDX_SNAP_L, 16'h0003, 2'h0);
		rdc(pfc_pkg::IDX_RX_ERR, 16'h0000, 2'h0);
		wr(pfc_pkg::IDX_PATH, 16'h0001, 2'h0);
		pulse(9'h100);
		pulse(9'h100);
		pulse(9'h140);
		pulse(9'h030);
		rdc(pfc_pkg::IDX_RX_ERR, 16'h0001, 2'h0);
		rdc(pfc_pkg::IDX_SNAP_L, 16'h0006, 2'h0);
		rdc(pfc_pkg::IDX_STATUS, 16'h4000, 2'h0);
		wr(pfc_pkg::IDX_IRQ_EN, 16'h0000, 2'h0);
		pulse(9'h180);
		wr(pfc_pkg::IDX_CHECKER_ENABLE, 16'h0000, 2'h0);
		pulse(9'h180);
		rdc(pfc_pkg::IDX_STATUS, 16'h0000, 2'h0);
		rdc(pfc_pkg::IDX_RX_ERR, 16'h0001, 2'h0);
		rdc(pfc_pkg::IDX_SNAP_L, 16'h0007, 2'h0);
		slow = 1'b1;
		wr(pfc_pkg::IDX_SNAP_L, 16'hFFFF, 2'h0);
		rdc(pfc_pkg::IDX_SNAP_L, 16'h0007, 2'h0);
		slow = 1'b0;
		rdc(16'h0100, 16'h0000, 2'h3);
		wr(16'h0100, 16'hFFFF, 2'h3);
		summarize();
	end
endmodule : testbench
